// ===== hw/id_bank_regs.svh
`ifndef ID_BANK_REGS_SVH
`define ID_BANK_REGS_SVH

// avalon geometry
`define ID_ADDR_W 18
`define ID_DATA_W 32
`define ID_REG_W 16

// register indexes; byte address is four times the index
`define ID_IDX_PROG 16'hF078
`define ID_IDX_MEM 16'hF07A
`define ID_IDX_CHIP 16'hF07C
`define ID_IDX_MAKER 16'hF07E

// maker_identity fields
`define ID_MAKER_HI 15
`define ID_MAKER_LO 5
`define ID_MAKER_TAIL_HI 4
`define ID_MAKER_TAIL_LO 0

// chip_identity fields
`define ID_CHIP_HI 15
`define ID_CHIP_LO 4
`define ID_REV_HI 3
`define ID_REV_LO 0

// memory_descriptor fields and codes
`define ID_MEMKIND_HI 15
`define ID_MEMKIND_LO 12
`define ID_MEMCAP_HI 11
`define ID_MEMCAP_LO 0
`define ID_INIT_FLAG_HI 15
`define ID_INIT_FLAG_LO 14
`define ID_MEMKIND_NONE 4'h0
`define ID_MEMKIND_MROM 4'h1
`define ID_MEMKIND_STD 4'h2
`define ID_MEMKIND_HPF 4'h3
`define ID_MEMKIND_BUSY 4'hF
`define ID_MEMCAP_CODE 12'h0D0
`define ID_KB_PER_UNIT 4
`define ID_MEM_FINAL 16'h30D0
`define ID_MEM_PRE_INIT 16'hF0D0

// programming_voltage_info fields and codes
`define ID_VPP_HI 15
`define ID_VPP_LO 8
`define ID_VDD_HI 7
`define ID_VDD_LO 0
`define ID_VPP_NONE 8'h00
`define ID_VDD_5V 8'h40
`define ID_VDD_SCALE 20
`define ID_VDD_DIV 256
`define ID_PROG_VALUE 16'h0040

`endif

// ===== hw/id_bank_pkg.sv
package id_bank_pkg;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_ACK = 2'b10
   } access_phase_t;

   typedef struct packed {
      access_phase_t phase;
      logic [31:0] rdata;
   } bank_state_t;

   typedef struct packed {
      logic ea_s1;
      logic ea_s2;
      logic strap_taken;
      logic boot_internal;
      logic flash_done;
   } tracker_state_t;

endpackage

// ===== hw/init_status_if.sv
`timescale 1ns/10ps
interface init_status_if;
   logic flash_ready;
   logic boot_internal;
   modport tracker (output flash_ready, output boot_internal);
   modport bank (input flash_ready, input boot_internal);
endinterface

// ===== hw/boot_init_tracker.sv
`timescale 1ns/10ps
module boot_init_tracker (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // pin and flash controller
   input wire logic external_access_pin_in,
   input wire logic flash_init_done_in,
   // status toward the bank
   init_status_if.tracker stat
);
   id_bank_pkg::tracker_state_t st_r;
   id_bank_pkg::tracker_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // the pin is asynchronous; the synchroniser runs even in reset so the
      // strap level is already settled when reset releases
      st_nxt.ea_s1 = external_access_pin_in;
      st_nxt.ea_s2 = st_r.ea_s1;
      if (sys_rst_in) begin
         st_nxt.strap_taken = 1'b0;
         st_nxt.boot_internal = 1'b0;
         st_nxt.flash_done = 1'b0;
      end else begin
         if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            st_nxt.boot_internal = st_r.ea_s2;
         end
         if (flash_init_done_in) begin
            st_nxt.flash_done = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      st_r <= st_nxt;
   end

   // internal boot means flash is already initialised
   assign stat.boot_internal = st_r.strap_taken ? st_r.boot_internal : st_r.ea_s2;
   assign stat.flash_ready = st_r.flash_done | stat.boot_internal;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_internal_boot_ready: assert property (
      stat.boot_internal |-> stat.flash_ready)
      else $error("internal boot but flash not ready");
   a_ready_stays_set: assert property (
      st_r.strap_taken && stat.flash_ready |=> stat.flash_ready)
      else $error("flash ready dropped");
   a_done_latched: assert property (
      flash_init_done_in |=> ##1 stat.flash_ready)
      else $error("flash done not reported");
endmodule

// ===== hw/identification_register_bank.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "id_bank_regs.svh"
module identification_register_bank #(
   parameter logic [10:0] MAKER_CODE = 11'h055, // arbitrary value
   parameter logic [4:0] MAKER_TAIL = 5'h01, // arbitrary value
   parameter logic [11:0] CHIP_CODE = 12'h5A1, // arbitrary value
   parameter logic [3:0] SILICON_REV = 4'h1, // arbitrary value
   parameter int MEM_SIZE_KB = 832
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // avalon-mm slave
   input wire logic [`ID_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [`ID_DATA_W-1:0] avs_writedata_in,
   output logic [`ID_DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // boot strap and flash controller
   input wire logic external_access_pin_in,
   input wire logic flash_init_done_in,
   // status
   output logic flash_ready_out
);

   localparam logic [11:0] CAP_FIELD = 12'(MEM_SIZE_KB / `ID_KB_PER_UNIT);

   generate
      if ((MEM_SIZE_KB % `ID_KB_PER_UNIT) != 0 ||
          MEM_SIZE_KB / `ID_KB_PER_UNIT > 4095 || MEM_SIZE_KB < 0) begin : g_bad_size
         $error("memory size must be a multiple of four kilobytes below 16 MB");
      end
   endgenerate

   init_status_if stat_if ();

   boot_init_tracker u_tracker (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .external_access_pin_in(external_access_pin_in),
      .flash_init_done_in(flash_init_done_in),
      .stat(stat_if.tracker)
   );

   id_bank_pkg::bank_state_t st_r;
   id_bank_pkg::bank_state_t st_nxt;

   // register images, fixed apart from the memory_descriptor kind nibble
   logic [`ID_REG_W-1:0] maker_identity;
   logic [`ID_REG_W-1:0] chip_identity;
   logic [`ID_REG_W-1:0] memory_descriptor;
   logic [`ID_REG_W-1:0] programming_voltage_info;
   logic [3:0] memory_kind_field;
   logic [`ID_ADDR_W-1:0] idx_addr;
   logic [`ID_ADDR_W-3:0] word_idx;
   logic hit_prog;
   logic hit_mem;
   logic hit_chip;
   logic hit_maker;
   logic req;
   logic [`ID_REG_W-1:0] sel_data;

   always_comb begin
      maker_identity = '0;
      maker_identity[`ID_MAKER_HI:`ID_MAKER_LO] = MAKER_CODE;
      maker_identity[`ID_MAKER_TAIL_HI:`ID_MAKER_TAIL_LO] = MAKER_TAIL;
   end

   always_comb begin
      chip_identity = '0;
      chip_identity[`ID_CHIP_HI:`ID_CHIP_LO] = CHIP_CODE;
      chip_identity[`ID_REV_HI:`ID_REV_LO] = SILICON_REV;
   end

   // the kind nibble doubles as the busy indicator: while flash is still
   // initialising it reads all ones, which sets bits 15 and 14
   assign memory_kind_field = stat_if.flash_ready ? `ID_MEMKIND_HPF
                                                  : `ID_MEMKIND_BUSY;

   always_comb begin
      memory_descriptor = '0;
      memory_descriptor[`ID_MEMKIND_HI:`ID_MEMKIND_LO] = memory_kind_field;
      memory_descriptor[`ID_MEMCAP_HI:`ID_MEMCAP_LO] = CAP_FIELD;
   end

   // voltage word is the same before and after init
   always_comb begin
      programming_voltage_info = '0;
      programming_voltage_info[`ID_VPP_HI:`ID_VPP_LO] = `ID_VPP_NONE;
      programming_voltage_info[`ID_VDD_HI:`ID_VDD_LO] = `ID_VDD_5V;
   end

   // address decode: low two bits must be zero, word index must match
   assign word_idx = avs_address_in[`ID_ADDR_W-1:2];
   assign idx_addr = avs_address_in;
   assign hit_prog = (word_idx == `ID_IDX_PROG) && (idx_addr[1:0] == 2'b00);
   assign hit_mem = (word_idx == `ID_IDX_MEM) && (idx_addr[1:0] == 2'b00);
   assign hit_chip = (word_idx == `ID_IDX_CHIP) && (idx_addr[1:0] == 2'b00);
   assign hit_maker = (word_idx == `ID_IDX_MAKER) && (idx_addr[1:0] == 2'b00);

   always_comb begin
      case (1'b1)
         hit_prog: begin
            sel_data = programming_voltage_info;
         end
         hit_mem: begin
            sel_data = memory_descriptor;
         end
         hit_chip: begin
            sel_data = chip_identity;
         end
         hit_maker: begin
            sel_data = maker_identity;
         end
         default: begin
            sel_data = '0;
         end
      endcase
   end

   assign req = avs_read_in | avs_write_in;

   // one wait cycle per access keeps readdata registered
   always_comb begin
      st_nxt = st_r;
      if (sys_rst_in) begin
         st_nxt.phase = id_bank_pkg::PH_IDLE;
         st_nxt.rdata = '0;
      end else begin
         case (st_r.phase)
            id_bank_pkg::PH_IDLE: begin
               if (req) begin
                  st_nxt.phase = id_bank_pkg::PH_ACK;
               end
               // writes never load anything; the bank has no storage
               if (avs_read_in) begin
                  st_nxt.rdata = {16'h0000, sel_data};
               end
            end
            id_bank_pkg::PH_ACK: begin
               st_nxt.phase = id_bank_pkg::PH_IDLE;
            end
            default: begin
               st_nxt.phase = id_bank_pkg::PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      st_r <= st_nxt;
   end

   assign avs_waitrequest_out = req && (st_r.phase != id_bank_pkg::PH_ACK);
   assign avs_readdata_out = st_r.rdata;
   assign flash_ready_out = stat_if.flash_ready;

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   logic rd_done;
   logic wr_done;
   logic [`ID_REG_W-1:0] rd_word;
   assign rd_done = avs_read_in && !avs_waitrequest_out;
   assign wr_done = avs_write_in && !avs_waitrequest_out;
   assign rd_word = avs_readdata_out[`ID_REG_W-1:0];

   a_maker_code_read: assert property (
      rd_done && hit_maker |->
         rd_word[`ID_MAKER_HI:`ID_MAKER_LO] == MAKER_CODE &&
         avs_readdata_out[31:16] == 16'h0000)
      else $error("maker register read wrong");

   a_chip_rev_read: assert property (
      rd_done && hit_chip |->
         rd_word == {CHIP_CODE, SILICON_REV})
      else $error("chip register read wrong");

   a_mem_final_read: assert property (
      rd_done && hit_mem && $past(stat_if.flash_ready) |->
         rd_word == `ID_MEM_FINAL)
      else $error("descriptor wrong after init");

   a_mem_busy_flags: assert property (
      rd_done && hit_mem && !$past(stat_if.flash_ready) |->
         rd_word[`ID_INIT_FLAG_HI:`ID_INIT_FLAG_LO] == 2'b11)
      else $error("init flags not high while busy");

   a_mem_pre_init: assert property (
      rd_done && hit_mem && !$past(stat_if.flash_ready) |->
         rd_word == `ID_MEM_PRE_INIT)
      else $error("descriptor wrong before init");

   a_mem_capacity: assert property (
      rd_done && hit_mem |->
         32'(rd_word[`ID_MEMCAP_HI:`ID_MEMCAP_LO]) * `ID_KB_PER_UNIT == MEM_SIZE_KB)
      else $error("capacity field wrong");

   a_prog_voltage: assert property (
      rd_done && hit_prog |-> rd_word == `ID_PROG_VALUE)
      else $error("voltage register wrong");

   a_vpp_none: assert property (
      rd_done && hit_prog |-> rd_word[`ID_VPP_HI:`ID_VPP_LO] == `ID_VPP_NONE)
      else $error("external supply field not zero");

   a_write_no_effect: assert property (
      avs_write_in && st_r.phase == id_bank_pkg::PH_IDLE |=> $stable(avs_readdata_out))
      else $error("write disturbed read data");

   a_unmapped_zero: assert property (
      rd_done && !(hit_prog || hit_mem || hit_chip || hit_maker) |->
         avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_flags_clear_ready: assert property (
      stat_if.flash_ready |->
         ##2 (memory_descriptor[`ID_INIT_FLAG_HI:`ID_INIT_FLAG_LO] == 2'b00))
      else $error("flags not cleared after init");

   a_wait_bounded: assert property (
      req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait longer than one cycle");

   a_upper_half_zero: assert property (
      rd_done |-> avs_readdata_out[31:16] == 16'h0000)
      else $error("upper read half not zero");

   a_flags_move_together: assert property (
      rd_done && hit_mem |->
         rd_word[`ID_INIT_FLAG_HI] == rd_word[`ID_INIT_FLAG_LO])
      else $error("init flags differ");

   a_flags_low_ready: assert property (
      rd_done && hit_mem && $past(stat_if.flash_ready) |->
         rd_word[`ID_INIT_FLAG_HI:`ID_INIT_FLAG_LO] == 2'b00)
      else $error("init flags still high after init");

   a_kind_high_perf: assert property (
      rd_done && hit_mem && $past(stat_if.flash_ready) |->
         rd_word[`ID_MEMKIND_HI:`ID_MEMKIND_LO] == `ID_MEMKIND_HPF)
      else $error("memory kind not high performance flash");

   a_kind_busy_code: assert property (
      rd_done && hit_mem && !$past(stat_if.flash_ready) |->
         rd_word[`ID_MEMKIND_HI:`ID_MEMKIND_LO] == `ID_MEMKIND_BUSY)
      else $error("memory kind not busy code before init");

   a_vdd_code: assert property (
      rd_done && hit_prog |-> rd_word[`ID_VDD_HI:`ID_VDD_LO] == `ID_VDD_5V)
      else $error("core supply field wrong");

   a_prog_pre_init: assert property (
      rd_done && hit_prog && !$past(stat_if.flash_ready) |-> rd_word == `ID_PROG_VALUE)
      else $error("voltage register wrong before init");

   a_ids_pre_init: assert property (
      rd_done && (hit_maker || hit_chip) && !$past(stat_if.flash_ready) |->
         rd_word == (hit_maker ? {MAKER_CODE, MAKER_TAIL} : {CHIP_CODE, SILICON_REV}))
      else $error("identity codes not final before init");

   // a done pulse inside reset is dropped on purpose, so it is not held against us
   a_ready_after_done: assert property (
      $past(flash_init_done_in) && !$past(sys_rst_in) |-> flash_ready_out)
      else $error("ready not raised after flash done");

   a_read_data_holds: assert property (
      !(avs_read_in && st_r.phase == id_bank_pkg::PH_IDLE) |=> $stable(avs_readdata_out))
      else $error("read data changed without a read");

   a_ack_one_cycle: assert property (
      st_r.phase == id_bank_pkg::PH_ACK |=> st_r.phase == id_bank_pkg::PH_IDLE)
      else $error("acknowledge phase longer than one cycle");

   a_wait_while_pending: assert property (
      req && st_r.phase == id_bank_pkg::PH_IDLE |-> avs_waitrequest_out)
      else $error("request answered without wait cycle");

   c_read_busy: cover property (rd_done && hit_mem && !$past(stat_if.flash_ready));
   c_read_ready: cover property (rd_done && hit_mem && $past(stat_if.flash_ready));
   c_write_ack: cover property (wr_done && hit_chip);
   c_read_unmapped: cover property (rd_done && !hit_maker && !hit_chip && !hit_mem && !hit_prog);
   c_internal_boot_read: cover property (rd_done && hit_mem && stat_if.boot_internal);

endmodule

// ===== tb/identification_register_bank_bench.sv
`timescale 1ns/10ps
`include "id_bank_regs.svh"
module identification_register_bank_bench;
   localparam logic [10:0] mk_code = 11'h055; // arbitrary value
   localparam logic [4:0] mk_tail = 5'h01; // arbitrary value
   localparam logic [11:0] chip_code = 12'h5a1; // arbitrary value
   localparam logic [3:0] rev = 4'h3; // arbitrary value
   localparam int mem_kb = 832;
   localparam logic [31:0] maker_exp = {16'h0000, mk_code, mk_tail};
   localparam logic [31:0] chip_exp = {16'h0000, chip_code, rev};
   logic ref_clk_in;
   logic sys_rst_in;
   logic [17:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic external_access_pin_in;
   logic flash_init_done_in;
   logic flash_ready_out;
   int n_mismatch;
   int tests_run;

   identification_register_bank #(.MAKER_CODE(mk_code), .MAKER_TAIL(mk_tail),
      .CHIP_CODE(chip_code), .SILICON_REV(rev), .MEM_SIZE_KB(mem_kb)
   ) u_identification_register_bank (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .external_access_pin_in(external_access_pin_in),
      .flash_init_done_in(flash_init_done_in),
      .flash_ready_out(flash_ready_out)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   task automatic results();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request stays up after the answering edge so back-to-back calls never
   // drop and raise it in one time step
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [1:0] sub,
                       output logic [31:0] d);
      logic done;
      done = 1'b0;
      d = 32'h0000_0000;
      avs_read_in <= ~wr;
      avs_write_in <= wr;
      avs_address_in <= {idx, sub};
      avs_writedata_in <= {16'h0000, ~idx};
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge ref_clk_in);
         // read before this edge's updates land, so these are the values that stood
         if (avs_waitrequest_out === 1'b0) begin
            d = avs_readdata_out;
            done = 1'b1;
         end
      end
      if (done !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] waitrequest expected 0 seen 1");
         results();
      end
   endtask

   task automatic idle();
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b0, idx, 2'b00, d);
      chk(what, exp, d);
   endtask

   task automatic rdy_chk(input logic exp);
      @(negedge ref_clk_in);
      chk("flash_ready_out", {31'h0000_0000, exp}, {31'h0000_0000, flash_ready_out});
      @(posedge ref_clk_in);
   endtask

   task automatic reset_dut(input logic pin);
      external_access_pin_in <= pin;
      sys_rst_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic t_pre_init();
      logic [31:0] d;
      reset_dut(1'b0);
      rdy_chk(1'b0);
      rd_chk("memory_descriptor", `ID_IDX_MEM, 32'h0000_f0d0);
      rd_chk("programming_voltage_info", `ID_IDX_PROG, 32'h0000_0040);
      rd_chk("chip_identity", `ID_IDX_CHIP, chip_exp);
      rd_chk("maker_identity", `ID_IDX_MAKER, maker_exp);
      rd_chk("unmapped", 16'hf076, 32'h0000_0000);
      xfer(1'b0, `ID_IDX_MEM, 2'b10, d);
      chk("misaligned", 32'h0000_0000, d);
      idle();
   endtask

   task automatic t_write_ignored();
      logic [31:0] d;
      xfer(1'b1, `ID_IDX_PROG, 2'b00, d);
      xfer(1'b1, `ID_IDX_MEM, 2'b00, d);
      xfer(1'b1, `ID_IDX_CHIP, 2'b00, d);
      xfer(1'b1, `ID_IDX_MAKER, 2'b00, d);
      idle();
      // flags must hold for as long as the flash controller stays silent
      repeat (20) @(posedge ref_clk_in);
      rd_chk("memory_descriptor", `ID_IDX_MEM, 32'h0000_f0d0);
      rd_chk("programming_voltage_info", `ID_IDX_PROG, 32'h0000_0040);
      rd_chk("chip_identity", `ID_IDX_CHIP, chip_exp);
      rd_chk("maker_identity", `ID_IDX_MAKER, maker_exp);
      idle();
   endtask

   task automatic t_init_done();
      logic [31:0] d;
      flash_init_done_in <= 1'b1;
      @(posedge ref_clk_in);
      flash_init_done_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rdy_chk(1'b1);
      xfer(1'b0, `ID_IDX_MEM, 2'b00, d);
      idle();
      chk("memory_kind_field", {28'h000_0000, `ID_MEMKIND_HPF}, {28'h000_0000, d[15:12]});
      chk("capacity_kb", 32'(mem_kb), {18'h0_0000, d[11:0], 2'b00});
      chk("init_flags", 32'h0000_0000, {30'h0000_0000, d[15:14]});
      xfer(1'b0, `ID_IDX_PROG, 2'b00, d);
      idle();
      chk("external_program_supply_field", 32'h0000_0000, {24'h00_0000, d[15:8]});
      chk("core_program_supply_field", 32'h0000_0040, {24'h00_0000, d[7:0]});
      chk("supply_volts", 32'h0000_0005,
          (32'h0000_0014 * {24'h00_0000, d[7:0]}) / 32'h0000_0100);
      xfer(1'b1, `ID_IDX_MEM, 2'b00, d);
      rd_chk("memory_descriptor", `ID_IDX_MEM, 32'h0000_30d0);
      rd_chk("chip_identity", `ID_IDX_CHIP, chip_exp);
      idle();
   endtask

   task automatic t_internal_boot();
      reset_dut(1'b1);
      rdy_chk(1'b1);
      rd_chk("memory_descriptor", `ID_IDX_MEM, 32'h0000_30d0);
      idle();
      // a fresh external boot must forget the earlier completion
      reset_dut(1'b0);
      rd_chk("memory_descriptor", `ID_IDX_MEM, 32'h0000_f0d0);
      idle();
   endtask

   initial begin
      n_mismatch = 0;
      tests_run = 0;
      sys_rst_in = 1'b1;
      avs_address_in = 18'h0_0000;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0000_0000;
      external_access_pin_in = 1'b0;
      flash_init_done_in = 1'b0;
      t_pre_init();
      t_write_ignored();
      t_init_done();
      t_internal_boot();
      results();
   end
endmodule
